// ---- verilog/ddrsr_core.sv ----
// Dual-port double-rate two-word burst SRAM core with echo clocks
`timescale 1ns/1ps
// Function
// - Separate read data outputs and write data inputs, running concurrently.
// - One address bus; read on true clock, write on complementary clock edge.
// - Each address holds two words; accesses burst both words in order, except a new read drops any pending read words not yet launched.
// - PLL disable high gives read latency of one and a half cycles.
// - PLL disable low gives read latency of one cycle.
// - All synchronous inputs are captured on true or complementary clock rises.
// - Read data launched on output clock rises, or input clocks if single domain.
// - Only rising edges act; both true and complementary clocks move data.
// - Echo clock pair driven aligned with returned read data.
// - Read and write port selects enable each port independently.
// - Writes complete internally, self-timed, from registered inputs only.
// - Reads return newest data for an address, including a write committed on the read launch edge.
module ddrsr_core import ddrsr_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic single_clock,
  input wire logic pll_disable,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [DDRSR_ADDR_W-1:0] addr,
  input wire logic [DDRSR_WORD_W-1:0] wr_data,
  output logic [DDRSR_WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic echo_clk,
  output logic echo_clk_n
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [DDRSR_ADDR_W-1:0] a1_q, a2_q;
  logic [DDRSR_WORD_W-1:0] d1_q, d2_q;
  assign pin_raw = {k_clk, k_clk_n, c_clk, c_clk_n, pll_disable,
                    read_port_select_n, write_port_select_n};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      a1_q <= '0;
      a2_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      a1_q <= addr;
      a2_q <= a1_q;
      d1_q <= wr_data;
      d2_q <= d1_q;
    end
  end

  // ------------------------------------------------------------
  // Edge detection on the synchronised clocks
  // ------------------------------------------------------------
  // Bits come in as arguments so every assign below follows them
  function automatic logic rise(input logic [1:0] pair);
    return pair == DDRSR_EDGE_RISE;
  endfunction : rise

  logic k_rise, kn_rise, c_rise, cn_rise, lat_pll, rsel, wsel;
  assign k_rise = rise({s3_q[6], s2_q[6]});
  assign kn_rise = rise({s3_q[5], s2_q[5]});
  assign c_rise = single_clock ? k_rise : rise({s3_q[4], s2_q[4]});
  assign cn_rise = single_clock ? kn_rise : rise({s3_q[3], s2_q[3]});
  assign lat_pll = s2_q[2];
  assign rsel = !s2_q[1];
  assign wsel = !s2_q[0];

  // ------------------------------------------------------------
  // Input capture and write path
  // ------------------------------------------------------------
  logic [DDRSR_WORD_W-1:0] mem [DDRSR_DEPTH*DDRSR_BURST];
  ddrsr_req_t rreq_q, rreq_d, wreq_q, wreq_d;
  logic [DDRSR_WORD_W-1:0] wlo_q, wlo_d;
  logic wphase_q, wphase_d;
  logic wcommit;
  always_comb begin
    rreq_d = rreq_q;
    wreq_d = wreq_q;
    wlo_d = wlo_q;
    wphase_d = wphase_q;
    wcommit = 1'b0;
    // read address on true clock rise
    if (k_rise) begin
      rreq_d.valid = rsel;
      // Hold the read address; a deselected cycle must not redirect a pending fetch
      if (rsel) begin
        rreq_d.addr = a2_q;
      end
    end
    // inputs registered on input clock rises
    if (kn_rise) begin
      wreq_d = '{valid: wsel, addr: a2_q};
      if (wsel) begin
        wphase_d = 1'b1;
      end
    end
    // first write word on K rise, second on K-bar rise
    if (k_rise && wphase_q) begin
      wlo_d = d2_q;
    end
    if (kn_rise && wphase_q) begin
      wcommit = wreq_q.valid;
      wphase_d = wsel;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rreq_q <= '0;
      wreq_q <= '0;
      wlo_q <= '0;
      wphase_q <= 1'b0;
    end else begin
      rreq_q <= rreq_d;
      wreq_q <= wreq_d;
      wlo_q <= wlo_d;
      wphase_q <= wphase_d;
    end
  end
  // ------------------------------------------------------------
  // Memory array, both burst words written in one commit
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wcommit) begin
      mem[{wreq_q.addr, 1'b0}] <= wlo_q;
      mem[{wreq_q.addr, 1'b1}] <= d2_q;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  ddrsr_burst_t rbuf_q, rbuf_d, fetch;
  logic [2:0] rcnt_q, rcnt_d;
  logic [2:0] lat_half;
  logic [DDRSR_WORD_W-1:0] rd_data_d;
  logic rd_valid_d, echo_d, echo_n_d, half_edge;
  // bypass a write being committed this cycle
  always_comb begin
    fetch.w0 = mem[{rreq_q.addr, 1'b0}];
    fetch.w1 = mem[{rreq_q.addr, 1'b1}];
    if (wcommit && wreq_q.addr == rreq_q.addr) begin
      fetch = '{w1: d2_q, w0: wlo_q};
    end
  end
  // one and a half cycles with PLL disable high; one cycle with it low
  assign lat_half = lat_pll ? 3'(DDRSR_LAT_PLL_HALF) : 3'(DDRSR_LAT_LEGACY_HALF);
  assign half_edge = c_rise || cn_rise;
  always_comb begin
    rbuf_d = rbuf_q;
    rcnt_d = rcnt_q;
    rd_data_d = rd_data;
    rd_valid_d = rd_valid;
    echo_d = echo_clk;
    echo_n_d = echo_clk_n;
    if (k_rise && rsel) begin
      rcnt_d = 3'h1;
    end else if (half_edge && rcnt_q != 3'h0) begin
      rcnt_d = rcnt_q + 3'h1;
      if (rcnt_q == lat_half) begin
        rbuf_d = fetch;
        rd_data_d = fetch.w0;
        rd_valid_d = 1'b1;
      end else if (rcnt_q == lat_half + 3'h1) begin
        rd_data_d = rbuf_q.w1;
        rcnt_d = 3'h0;
      end
    end else if (half_edge && rd_valid && rcnt_q == 3'h0) begin
      rd_valid_d = 1'b0;
    end
    // echo clocks follow the output clocks, or the input clocks in one clock domain
    if (c_rise) begin
      echo_d = 1'b1;
      echo_n_d = 1'b0;
    end else if (cn_rise) begin
      echo_d = 1'b0;
      echo_n_d = 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  // dedicated read output register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rbuf_q <= '0;
      rcnt_q <= 3'h0;
      rd_data <= DDRSR_DATA_RST;
      rd_valid <= 1'b0;
      echo_clk <= 1'b0;
      echo_clk_n <= 1'b0;
    end else begin
      rbuf_q <= rbuf_d;
      rcnt_q <= rcnt_d;
      rd_data <= rd_data_d;
      rd_valid <= rd_valid_d;
      echo_clk <= echo_d;
      echo_clk_n <= echo_n_d;
    end
  end
endmodule : ddrsr_core

// ---- shared/ddrsr_pkg.sv ----
// Constants and carrier types for the dual-port burst SRAM interface
package ddrsr_pkg;
  localparam int DDRSR_WORD_W = 18;
  localparam int DDRSR_ADDR_W = 6;
  localparam int DDRSR_DEPTH = 64;
  localparam int DDRSR_BURST = 2;
  localparam int DDRSR_SYNC_STAGES = 2;
  // Read latency in half cycles of the input clock
  localparam int DDRSR_LAT_PLL_HALF = 3;
  localparam int DDRSR_LAT_LEGACY_HALF = 2;
  localparam logic [1:0] DDRSR_EDGE_RISE = 2'b01;
  localparam logic [DDRSR_WORD_W-1:0] DDRSR_DATA_RST = 18'h00000;

  typedef struct packed {
    logic [DDRSR_WORD_W-1:0] w1;
    logic [DDRSR_WORD_W-1:0] w0;
  } ddrsr_burst_t;

  typedef struct packed {
    logic valid;
    logic [DDRSR_ADDR_W-1:0] addr;
  } ddrsr_req_t;
endpackage : ddrsr_pkg

// ---- test/ddrsr_core_properties.sv ----
// Port checks for the burst SRAM core
`timescale 1ns/1ps
module ddrsr_core_properties import ddrsr_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic single_clock,
  input wire logic pll_disable,
  input wire logic read_port_select_n,
  input wire logic [DDRSR_WORD_W-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic echo_clk,
  input wire logic echo_clk_n
);
  logic [6:0] idle_q;
  logic [6:0] idle_d;
  // Cycles since read select was last low
  always_comb idle_d = !read_port_select_n ? 7'h00 : idle_q + {6'h00, idle_q != 7'h7f};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) idle_q <= 7'h7f;
    else idle_q <= idle_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_burst_two_words: assert property ($rose(rd_valid) |-> rd_valid [*8] ##[20:40] !rd_valid)
    else $error("burst length");
  a_latency_pll: assert property ($rose(rd_valid) && pll_disable |-> idle_q inside {[36:56]})
    else $error("pll latency");
  a_latency_legacy: assert property ($rose(rd_valid) && !pll_disable |-> idle_q inside {[20:34]})
    else $error("legacy latency");
  a_select_gates_read: assert property (idle_q == 7'd100 |-> !rd_valid)
    else $error("read without select");
  a_echo_true: assert property ($rose(c_clk) && !single_clock |-> ##[1:6] echo_clk)
    else $error("echo true");
  a_echo_comp: assert property ($rose(c_clk_n) && !single_clock |-> ##[1:6] echo_clk_n)
    else $error("echo comp");
  a_data_on_echo: assert property ($changed(rd_data) |-> $changed(echo_clk) || $changed(echo_clk_n))
    else $error("data off edge");
  a_valid_on_echo: assert property ($rose(rd_valid) |-> $changed(echo_clk) || $changed(echo_clk_n))
    else $error("valid off edge");
endmodule : ddrsr_core_properties
bind ddrsr_core ddrsr_core_properties chk (
  .mclk(mclk),
  .nrst(nrst),
  .c_clk(c_clk),
  .c_clk_n(c_clk_n),
  .single_clock(single_clock),
  .pll_disable(pll_disable),
  .read_port_select_n(read_port_select_n),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .echo_clk(echo_clk),
  .echo_clk_n(echo_clk_n)
);

// ---- test/ddrsr_ctrl_model.sv ----
// Controller clock source for the burst SRAM bench
`timescale 1ns/1ps
module ddrsr_ctrl_model (
  input wire logic single_clock,
  output logic k_clk,
  output logic k_clk_n,
  output logic c_clk,
  output logic c_clk_n
);
  // complementary pair, phase free of mclk
  initial begin
    k_clk = 1'b0;
    #1.3;
    forever #80 k_clk = !k_clk;
  end
  assign k_clk_n = !k_clk;
  // output clocks follow the input clocks, held high in one clock domain
  assign c_clk = single_clock ? 1'b1 : k_clk;
  assign c_clk_n = single_clock ? 1'b1 : k_clk_n;
endmodule : ddrsr_ctrl_model

// ---- test/ddrsr_core_test.sv ----
// Bench for the burst SRAM core
`timescale 1ns/1ps
module ddrsr_core_test;
  import ddrsr_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, single_clock = 1'b0, pll_disable = 1'b1;
  logic read_port_select_n = 1'b1, write_port_select_n = 1'b1;
  logic [DDRSR_ADDR_W-1:0] addr = '0;
  logic [DDRSR_WORD_W-1:0] wr_data = '0, rd_data, d0;
  logic rd_valid, echo_clk, echo_clk_n, k_clk, k_clk_n, c_clk, c_clk_n;
  int num_errors = 0, checks_done = 0, hcnt = 0, rk, lat;
  always #2.5 mclk = !mclk;
  always @(posedge k_clk or posedge k_clk_n) hcnt++;
  ddrsr_ctrl_model ctrl (
    .single_clock(single_clock),
    .k_clk(k_clk),
    .k_clk_n(k_clk_n),
    .c_clk(c_clk),
    .c_clk_n(c_clk_n)
  );
  ddrsr_core uut (
    .mclk(mclk),
    .nrst(nrst),
    .k_clk(k_clk),
    .k_clk_n(k_clk_n),
    .c_clk(c_clk),
    .c_clk_n(c_clk_n),
    .single_clock(single_clock),
    .pll_disable(pll_disable),
    .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .echo_clk(echo_clk),
    .echo_clk_n(echo_clk_n)
  );
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cmp(input string n, input logic [DDRSR_WORD_W-1:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // Sets the pins for the next clock half edge
  task automatic step(input logic rs, ws, input logic [DDRSR_ADDR_W-1:0] a,
      input logic [DDRSR_WORD_W-1:0] d);
    @(posedge k_clk or posedge k_clk_n);
    repeat (8) @(posedge mclk);
    read_port_select_n <= rs;
    write_port_select_n <= ws;
    addr <= a;
    wr_data <= d;
  endtask : step
  task automatic tr(input logic [DDRSR_ADDR_W-1:0] a, input logic [DDRSR_WORD_W-1:0] w0, w1,
      e0, e1, input logic wsn, rsn);
    int i;
    @(posedge k_clk);
    step(1'b1, 1'b1, a, w1);
    // write on complementary edge, read on true edge
    step(1'b1, wsn, a, w1);
    step(1'b1, 1'b1, a, w0);
    step(1'b1, 1'b1, a, w1);
    step(rsn, 1'b1, a, w0);
    step(1'b1, 1'b1, ~a, w0);
    rk = hcnt;
    for (i = 0; i < 120 && rd_valid !== 1'b1; i++) @(negedge mclk);
    if (rsn) cmp("valid", 18'h0, 18'(rd_valid));
    else begin
      cmp("latency", 18'(lat), 18'(hcnt - rk));
      cmp("word0", e0, rd_data);
      @(posedge k_clk or posedge k_clk_n);
      repeat (8) @(negedge mclk);
      cmp("word1", e1, rd_data);
    end
    @(posedge mclk);
  endtask : tr
  // Read whose output edge meets the commit of a write to the same address
  task automatic coherent(input logic [DDRSR_ADDR_W-1:0] a,
      input logic [DDRSR_WORD_W-1:0] w0, w1);
    @(posedge k_clk);
    step(1'b0, 1'b1, a, w0);
    step(1'b1, 1'b0, a, w0);
    step(1'b1, 1'b1, a, w0);
    step(1'b1, 1'b1, a, w1);
    step(1'b1, 1'b1, a, w1);
    @(negedge mclk);
    cmp("bypass valid", 18'h00001, 18'(rd_valid));
    cmp("bypass word0", w0, rd_data);
    @(posedge k_clk or posedge k_clk_n);
    repeat (8) @(negedge mclk);
    cmp("bypass word1", w1, rd_data);
    @(posedge mclk);
  endtask : coherent
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int p = 1; p >= 0; p--) begin
      pll_disable <= p[0];
      lat = p ? DDRSR_LAT_PLL_HALF : DDRSR_LAT_LEGACY_HALF;
      d0 = 18'h1a2b3 ^ 18'(p);
      tr(6'h05, d0, ~d0, d0, ~d0, 1'b0, 1'b0);
      tr(6'h05, 18'h3ffff, 18'h00000, d0, ~d0, 1'b1, 1'b0);
      tr(6'h3f, d0, d0, d0, d0, 1'b0, 1'b1);
    end
    pll_disable <= 1'b1;
    lat = DDRSR_LAT_PLL_HALF;
    coherent(6'h05, 18'h0c3a5, 18'h3125e);
    single_clock <= 1'b1;
    tr(6'h2a, 18'h2c0d5, 18'h13f2a, 18'h2c0d5, 18'h13f2a, 1'b0, 1'b0);
    summarize();
  end
  initial begin
    #60000;
    num_errors++;
    summarize();
  end
endmodule : ddrsr_core_test
